/* File: design/sbk_burst_seq.sv */
// Burst read sequencer: walks the seven burst bytes and clears motion.
// Assumes the top gates step with no register read in the same cycle.
`timescale 1ns/10ps
`include "sbk_consts.svh"
module sbk_burst_seq (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    sbk_core_if.burst bus
);
    import sbk_pkg::*;

    logic [2:0] next_idx; // Index of the byte the step delivers
    logic       take;     // A step accepted during a burst

    always_comb begin
        next_idx = 3'(bus.idx + 3'd1);
        take     = bus.step && bus.active;
    end

    // ****************************************
    // Sequence position
    // ****************************************
    // Ends on stop or after the last byte; a new start restarts it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus.active <= 1'b0;
            bus.idx    <= 3'd0;
        end else if (ce) begin
            if (bus.soft_rst) begin
                bus.active <= 1'b0;
                bus.idx    <= 3'd0;
            end else if (bus.start) begin
                bus.active <= 1'b1;
                bus.idx    <= 3'd0;
            end else if (bus.stop) begin
                bus.active <= 1'b0;
            end else if (take) begin
                bus.idx <= next_idx;
                if (next_idx == `SBK_BURST_LAST) begin
                    bus.active <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Motion clear
    // ****************************************
    // Short bursts leave motion intact, so hosts must take three bytes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus.clear <= 1'b0;
        end else if (ce) begin
            bus.clear <= take && !bus.soft_rst && !bus.start
                         && !bus.stop && next_idx == `SBK_BURST_CLEAR;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_burst_ends: assert property (
        (ce && take && !bus.start && !bus.stop && !bus.soft_rst
         && next_idx == `SBK_BURST_LAST) |=> !bus.active)
        else $error("Burst did not end after last byte");
endmodule : sbk_burst_seq

/* File: design/sbk_consts.svh */
// Constants of the sensor configuration and status register bank.
// Assumes inclusion by bare name from the design files.
`ifndef SBK_CONSTS_SVH
`define SBK_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SBK_ADDR_CONFIG   7'h11
`define SBK_ADDR_ACTIVITY 7'h2e
`define SBK_ADDR_RESET    7'h3a
`define SBK_ADDR_INV_REV  7'h3e
`define SBK_ADDR_INV_PART 7'h3f
`define SBK_ADDR_BURST    7'h42

// ****************************************
// Reset values and keys
// ****************************************
`define SBK_CONFIG_RESET  8'h03
`define SBK_RESET_KEY     8'h5a
`define SBK_ACT_SET       4'hf
`define SBK_ACT_CLEAR     4'h0

// ****************************************
// Field positions
// ****************************************
`define SBK_CFG_RES_BIT   7
`define SBK_CFG_SLEEP_MSB 5
`define SBK_CFG_SLEEP_LSB 4

// ****************************************
// Burst sequence counts
// ****************************************
`define SBK_BURST_LAST    3'd6
`define SBK_BURST_CLEAR   3'd2

`endif

/* File: design/sbk_core_if.sv */
// Carrier between the register bank top and its power and burst helpers.
// Assumes all parties run on the same clock.
`timescale 1ns/10ps
interface sbk_core_if;
    import sbk_pkg::*;
    logic [1:0] forced_level; // Forced sleep level from config
    logic [1:0] auto_level;   // Level asked by automatic power logic
    sbk_pwr_t   state;        // Current power state
    logic [1:0] mode;         // Current mode code for readback
    logic       soft_rst;     // Key-triggered chip reset
    logic       start;        // Burst read begins
    logic       step;         // Next burst byte requested
    logic       stop;         // Burst ends early
    logic       active;       // Burst in progress
    logic [2:0] idx;          // Index of the last burst byte given
    logic       clear;        // Pulse: clear accumulated motion
    modport pwr (input forced_level, auto_level, soft_rst, output state, mode);
    modport burst (input start, step, stop, soft_rst, output active, idx, clear);
    modport top (output forced_level, auto_level, soft_rst, start, step, stop,
                 input state, mode, active, idx, clear);
endinterface : sbk_core_if

/* File: design/sbk_pkg.sv */
// Types shared by the register bank and its helper modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sbk_pkg;
    // Byte on the register port
    typedef logic [7:0] sbk_byte_t;
    // Register address on the register port
    typedef logic [6:0] sbk_addr_t;
    // Power states, Gray along run and the three sleep levels
    typedef enum logic [1:0] {
        SBK_RUN  = 2'b00,
        SBK_LVL1 = 2'b01,
        SBK_LVL2 = 2'b11,
        SBK_LVL3 = 2'b10
    } sbk_pwr_t;
endpackage : sbk_pkg

/* File: design/sbk_power_ctl.sv */
// Power state holder: forced sleep level overrides automatic management.
// Assumes auto_level comes from the automatic power manager.
`timescale 1ns/10ps
`include "sbk_consts.svh"
module sbk_power_ctl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    sbk_core_if.pwr  bus
);
    import sbk_pkg::*;

    // ****************************************
    // Level selection
    // ****************************************
    logic [1:0] next_level; // Level the chip must sit in next
    sbk_pwr_t   next_state; // Matching Gray state

    // A nonzero forced level wins; automatic control is then ignored
    always_comb begin
        next_level = (bus.forced_level != 2'b00) ? bus.forced_level
                                                 : bus.auto_level;
        unique case (next_level)
            2'b00: next_state = SBK_RUN;
            2'b01: next_state = SBK_LVL1;
            2'b10: next_state = SBK_LVL2;
            2'b11: next_state = SBK_LVL3;
        endcase
    end

    // State and its mode code move together so readback never tears
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus.state <= SBK_RUN;
            bus.mode  <= 2'b00;
        end else if (ce) begin
            if (bus.soft_rst) begin
                bus.state <= SBK_RUN;
                bus.mode  <= 2'b00;
            end else begin
                bus.state <= next_state;
                bus.mode  <= next_level;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_auto_follow: assert property (
        (ce && bus.forced_level == 2'b00 && !bus.soft_rst)
        |=> bus.mode == $past(bus.auto_level))
        else $error("Mode did not follow automatic level");
    chk_forced_hold: assert property (
        (ce && bus.forced_level == 2'b11 && !bus.soft_rst)
        |=> bus.state == SBK_LVL3)
        else $error("Forced third level not entered");
endmodule : sbk_power_ctl

/* File: design/sbk_regs.sv */
// Sensor configuration and status register bank, top level.
// Assumes a serial port front end gives one-cycle read/write strobes.
//
// Functional notes
// - Config register at 0x11, resets to 0x03
// - Sleep field picks run or sleep level
// - Nonzero sleep field overrides automatic power control
// - Config bit 7 selects 500 or 1000
// - Each frame sets four activity bits
// - Any activity register write clears activity bits, unless a frame lands in the same cycle
// - Activity register top bits show power mode
// - Key 0x5a at 0x3a resets all settings
// - Address 0x3e reads inverted revision code
// - Address 0x3f reads inverted part code
// - Read 0x42 starts seven-byte burst sequence
// - Third burst byte read clears motion data
`timescale 1ns/10ps
`include "sbk_consts.svh"
module sbk_regs #(
    // Arbitrary identification values, not tied to any real part
    parameter sbk_pkg::sbk_byte_t REV_ID  = 8'h15,
    parameter sbk_pkg::sbk_byte_t PART_ID = 8'h2a
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               ce,
    input  wire sbk_pkg::sbk_addr_t reg_addr,
    input  wire sbk_pkg::sbk_byte_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic               burst_next,
    input  wire logic               burst_end,
    input  wire logic               frame_done,
    input  wire logic [1:0]         auto_level,
    input  wire sbk_pkg::sbk_byte_t motion_status,
    input  wire sbk_pkg::sbk_byte_t delta_y,
    input  wire sbk_pkg::sbk_byte_t delta_x,
    input  wire sbk_pkg::sbk_byte_t squal,
    input  wire sbk_pkg::sbk_byte_t shutter_upper,
    input  wire sbk_pkg::sbk_byte_t shutter_lower,
    input  wire sbk_pkg::sbk_byte_t max_pixel,
    output sbk_pkg::sbk_byte_t      rd_data,
    output logic                    rd_valid,
    output logic                    res_1000,
    output logic [1:0]              power_mode,
    output logic                    motion_clear,
    output logic                    chip_reset
);
    import sbk_pkg::*;

    // ****************************************
    // Storage and decode
    // ****************************************
    sbk_core_if ifc ();              // Link to the helpers
    sbk_byte_t  sensor_config;       // Resolution and sleep level
    logic [3:0] frame_activity_bits; // Set by frames, cleared by writes
    logic       wr_config;           // Write to the config register
    logic       wr_activity;         // Write to the activity register
    logic       key_hit;             // Correct reset key written
    logic       burst_take;          // Burst byte handed out this cycle
    sbk_byte_t  next_data;           // Read data to register
    logic       next_valid;          // Read answer to register

    // Address decode; reserved addresses match nothing and are dropped
    always_comb begin
        wr_config   = reg_wr && reg_addr == `SBK_ADDR_CONFIG;
        wr_activity = reg_wr && reg_addr == `SBK_ADDR_ACTIVITY;
        key_hit     = reg_wr && reg_addr == `SBK_ADDR_RESET
                      && reg_wdata == `SBK_RESET_KEY;
        burst_take  = burst_next && !reg_rd && ifc.active;
    end

    // ****************************************
    // Helper wiring
    // ****************************************
    assign ifc.forced_level = sensor_config[`SBK_CFG_SLEEP_MSB:`SBK_CFG_SLEEP_LSB];
    assign ifc.auto_level   = auto_level;
    assign ifc.soft_rst     = chip_reset;
    // Register reads win over burst steps in the same cycle
    assign ifc.start        = reg_rd && reg_addr == `SBK_ADDR_BURST;
    assign ifc.step         = burst_next && !reg_rd;
    assign ifc.stop         = burst_end && !ifc.start;
    // Both outputs are flip-flops inside the helpers
    assign power_mode       = ifc.mode;
    assign motion_clear     = ifc.clear;

    // Power state holder
    sbk_power_ctl u_pwr (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .bus    (ifc.pwr)
    );

    // Burst sequencer
    sbk_burst_seq u_burst (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .bus    (ifc.burst)
    );

    // ****************************************
    // Configuration register
    // ****************************************
    // Reset key returns it to default one cycle after the chip_reset pulse, two after the key write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sensor_config <= `SBK_CONFIG_RESET;
        end else if (ce) begin
            if (chip_reset) begin
                sensor_config <= `SBK_CONFIG_RESET;
            end else if (wr_config) begin
                sensor_config <= reg_wdata;
            end
        end
    end

    // Resolution select is the top config bit, itself a flip-flop
    assign res_1000 = sensor_config[`SBK_CFG_RES_BIT];

    // ****************************************
    // Frame activity bits
    // ****************************************
    // A frame in the same cycle as a clearing write wins, so no frame is lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frame_activity_bits <= `SBK_ACT_CLEAR;
        end else if (ce) begin
            if (chip_reset) begin
                frame_activity_bits <= `SBK_ACT_CLEAR;
            end else if (frame_done) begin
                frame_activity_bits <= `SBK_ACT_SET;
            end else if (wr_activity) begin
                frame_activity_bits <= `SBK_ACT_CLEAR;
            end
        end
    end

    // ****************************************
    // Soft reset
    // ****************************************
    // One-cycle pulse; any other value at this address is ignored
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chip_reset <= 1'b0;
        end else if (ce) begin
            chip_reset <= key_hit;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Burst byte by position in the sequence
    function automatic sbk_byte_t pick_byte(input logic [2:0] i);
        case (i)
            3'd0:    pick_byte = motion_status;
            3'd1:    pick_byte = delta_y;
            3'd2:    pick_byte = delta_x;
            3'd3:    pick_byte = squal;
            3'd4:    pick_byte = shutter_upper;
            3'd5:    pick_byte = shutter_lower;
            default: pick_byte = max_pixel;
        endcase
    endfunction : pick_byte

    // Answer mux; write-only and reserved addresses read as zero
    always_comb begin
        next_valid = 1'b0;
        next_data  = 8'h00;
        if (reg_rd) begin
            next_valid = 1'b1;
            case (reg_addr)
                `SBK_ADDR_CONFIG:   next_data = sensor_config;
                `SBK_ADDR_ACTIVITY: next_data = {ifc.mode, 2'b00,
                                                 frame_activity_bits};
                `SBK_ADDR_INV_REV:  next_data = ~REV_ID;
                `SBK_ADDR_INV_PART: next_data = ~PART_ID;
                `SBK_ADDR_BURST:    next_data = pick_byte(3'd0);
                default:            next_data = 8'h00;
            endcase
        end else if (burst_take) begin
            next_valid = 1'b1;
            next_data  = pick_byte(3'(ifc.idx + 3'd1));
        end
    end

    // Answers are registered so the port sees clean flip-flop outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_data  <= next_data;
            rd_valid <= next_valid;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Power-on value
    chk_cfg_reset_value: assert property (
        !$past(resetn) |-> sensor_config == `SBK_CONFIG_RESET)
        else $error("Config not at reset value");

    // Plain config write
    chk_cfg_write_lands: assert property (
        (ce && wr_config && !chip_reset)
        |=> sensor_config == $past(reg_wdata))
        else $error("Config write lost");

    // Forced level reaches the mode output
    chk_forced_level: assert property (
        (ce && ifc.forced_level != 2'b00 && !chip_reset)
        |=> power_mode == $past(ifc.forced_level))
        else $error("Forced level not reported");

    // Resolution bit follows the write
    chk_res_select: assert property (
        (ce && wr_config && !chip_reset)
        |=> res_1000 == $past(reg_wdata[7]))
        else $error("Resolution select wrong");

    // A frame sets the bits
    chk_frame_sets: assert property (
        (ce && frame_done && !chip_reset) |=> frame_activity_bits == 4'hf)
        else $error("Frame did not set activity bits");

    // Clearing write
    chk_write_clears: assert property (
        (ce && wr_activity && !frame_done && !chip_reset)
        |=> frame_activity_bits == 4'h0)
        else $error("Write did not clear activity bits");

    // Mode field on readback
    chk_mode_readback: assert property (
        (ce && reg_rd && reg_addr == `SBK_ADDR_ACTIVITY)
        |=> rd_valid && rd_data[7:6] == $past(ifc.mode))
        else $error("Mode bits wrong on readback");

    // Correct key restores defaults
    chk_key_resets: assert property (
        (ce && key_hit) ##1 ce |-> chip_reset ##1 sensor_config == 8'h03)
        else $error("Reset key did not restore config");

    // Soft reset also drops power state, burst and bits
    chk_soft_to_run: assert property (
        (ce && chip_reset) |=> power_mode == 2'b00 && !ifc.active
        && frame_activity_bits == `SBK_ACT_CLEAR)
        else $error("Soft reset left state behind");

    // Wrong key does nothing
    chk_bad_key: assert property (
        (ce && reg_wr && reg_addr == `SBK_ADDR_RESET
         && reg_wdata != `SBK_RESET_KEY) |=> !chip_reset)
        else $error("Wrong key caused reset");

    // Identity readbacks
    chk_inv_rev: assert property (
        (ce && reg_rd && reg_addr == `SBK_ADDR_INV_REV)
        |=> rd_data == ~REV_ID)
        else $error("Inverted revision code wrong");

    chk_inv_part: assert property (
        (ce && reg_rd && reg_addr == `SBK_ADDR_INV_PART)
        |=> rd_data == ~PART_ID)
        else $error("Inverted part code wrong");

    // Burst opens with the motion status byte
    chk_burst_first: assert property (
        (ce && ifc.start) |=> rd_valid && rd_data == $past(motion_status))
        else $error("Burst did not open with motion status");

    // Steps outside a burst get no answer
    chk_idle_step: assert property (
        (ce && burst_next && !reg_rd && !ifc.active) |=> !rd_valid)
        else $error("Step outside a burst answered");

    // Delivering the third byte clears motion, however far apart the steps
    chk_clear_third: assert property (
        (ce && burst_take && ifc.idx == 3'd1 && !burst_end && !chip_reset)
        |=> motion_clear)
        else $error("Motion not cleared after third byte");

    // Reserved range reads zero
    chk_reserved_zero: assert property (
        (ce && reg_rd && reg_addr > `SBK_ADDR_CONFIG
         && reg_addr < `SBK_ADDR_ACTIVITY) |=> rd_data == 8'h00)
        else $error("Reserved address read nonzero");

    // Main scenarios
    cov_full_burst: cover property (ce && ifc.start ##[1:20] (ifc.idx == 3'd6 && !ifc.active));
    cov_short_burst: cover property (ce && ifc.stop && ifc.active && ifc.idx == 3'd1);
    cov_forced_sleep: cover property (power_mode == 2'b11 && ifc.forced_level == 2'b11);
    cov_key_reset: cover property (chip_reset ##1 sensor_config == 8'h03);
endmodule : sbk_regs

/* File: verif/sbk_host.sv */
// Host model: serial port master reduced to one-cycle strobe transfers.
// Assumes the register bank answers reads with rd_valid within a few cycles.
`timescale 1ns/10ps
module sbk_host (
    input  wire logic               clk,
    input  wire sbk_pkg::sbk_byte_t rd_data,
    input  wire logic               rd_valid,
    output sbk_pkg::sbk_addr_t      reg_addr,
    output sbk_pkg::sbk_byte_t      reg_wdata,
    output logic                    reg_wr,
    output logic                    reg_rd,
    output logic                    burst_next,
    output logic                    burst_end
);
    import sbk_pkg::*;
    // ****************************************
    // Transfers
    // ****************************************
    // Idle port, strobes low
    initial begin
        reg_addr   = 7'h00;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        burst_next = 1'b0;
        burst_end  = 1'b0;
    end
    // Read or burst step; callers read at least three burst bytes, one breach aside
    task automatic xfer(input logic nxt, input sbk_addr_t a, output sbk_byte_t d,
                        output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge clk);
        reg_addr   <= a;
        reg_rd     <= ~nxt;
        burst_next <= nxt;
        @(posedge clk);
        reg_rd     <= 1'b0;
        burst_next <= 1'b0;
        // Released address shows garbage, so stale values never pass
        reg_addr   <= ~a;
        // Bounded wait for the answer
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d  = rd_data;
            end else begin
                @(posedge clk);
            end
        end
    endtask : xfer
    // Register write, no answer expected
    task automatic wr(input sbk_addr_t a, input sbk_byte_t v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask : wr
    // Early end of a burst, as when chip select rises
    task automatic stop();
        @(posedge clk);
        burst_end <= 1'b1;
        @(posedge clk);
        burst_end <= 1'b0;
    endtask : stop
endmodule : sbk_host

/* File: verif/tb_sensor_config_status_regs.sv */
// Testbench of the register bank: table of plain accesses, then hand tests.
// Assumes sbk_regs and sbk_host compiled before it.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    fail_count++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_sensor_config_status_regs;
    import sbk_pkg::*;
    // Arbitrary identification values, not tied to any real part
    localparam sbk_byte_t REV_ID  = 8'h3c;
    localparam sbk_byte_t PART_ID = 8'h96;
    typedef struct {
        logic w; sbk_addr_t wa; sbk_byte_t wd; sbk_addr_t ra; sbk_byte_t er;
        logic eres; logic [1:0] epm;
    } sbk_row_t;
    logic       clk, resetn, ce, frame_done, reg_wr, reg_rd, burst_next, burst_end;
    logic [1:0] auto_level, power_mode;
    logic       rd_valid, res_1000, motion_clear, chip_reset, ok;
    sbk_addr_t  reg_addr;
    sbk_byte_t  reg_wdata, rd_data, d;
    sbk_byte_t  src [7] = '{8'h81, 8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'h67};
    int         fail_count, samples_checked, n_clear, n_soft;
    // ****************************************
    // Plain cases: optional write, then a read
    // ****************************************
    sbk_row_t rows [12] = '{
        '{1'b0, 7'h00, 8'h00, 7'h11, 8'h03, 1'b0, 2'h0},
        '{1'b1, 7'h11, 8'h80, 7'h11, 8'h80, 1'b1, 2'h0},
        '{1'b1, 7'h11, 8'h10, 7'h11, 8'h10, 1'b0, 2'h1},
        '{1'b1, 7'h11, 8'h20, 7'h2e, 8'h80, 1'b0, 2'h2},
        '{1'b1, 7'h11, 8'h30, 7'h2e, 8'hc0, 1'b0, 2'h3},
        '{1'b1, 7'h11, 8'h00, 7'h3e, ~REV_ID, 1'b0, 2'h0},
        '{1'b0, 7'h00, 8'h00, 7'h3f, ~PART_ID, 1'b0, 2'h0},
        '{1'b1, 7'h20, 8'hff, 7'h20, 8'h00, 1'b0, 2'h0},
        '{1'b1, 7'h3e, 8'h00, 7'h3e, ~REV_ID, 1'b0, 2'h0},
        '{1'b1, 7'h3a, 8'h12, 7'h11, 8'h00, 1'b0, 2'h0},
        '{1'b0, 7'h00, 8'h00, 7'h3a, 8'h00, 1'b0, 2'h0},
        '{1'b0, 7'h00, 8'h00, 7'h41, 8'h00, 1'b0, 2'h0}};
    sbk_regs #(.REV_ID(REV_ID), .PART_ID(PART_ID)) uut (
        .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .burst_next(burst_next), .burst_end(burst_end), .frame_done(frame_done),
        .auto_level(auto_level), .motion_status(src[0]), .delta_y(src[1]),
        .delta_x(src[2]), .squal(src[3]), .shutter_upper(src[4]),
        .shutter_lower(src[5]), .max_pixel(src[6]), .rd_data(rd_data),
        .rd_valid(rd_valid), .res_1000(res_1000), .power_mode(power_mode),
        .motion_clear(motion_clear), .chip_reset(chip_reset));
    sbk_host host (
        .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .burst_next(burst_next), .burst_end(burst_end));
    // Clock, 20 ns period
    always #10 clk = ~clk;
    // Pulse counters; pulses are one cycle so each is seen once
    always @(posedge clk) begin
        if (motion_clear === 1'b1) n_clear++;
        if (chip_reset === 1'b1) n_soft++;
    end
    // Verdict and end of run
    task automatic finish_test();
        $display("Checks %0d, errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // Read or step that must be answered; a missing answer ends the run
    task automatic rd(input logic nxt, input sbk_addr_t a, output sbk_byte_t v);
        logic got;
        host.xfer(nxt, a, v, got);
        if (got !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask : rd
    // One processed frame
    task automatic frame();
        @(posedge clk);
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
    endtask : frame
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 1'b0; resetn = 1'b0; ce = 1'b1; frame_done = 1'b0; auto_level = 2'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                host.wr(rows[i].wa, rows[i].wd);
            rd(1'b0, rows[i].ra, d);
            `CHK("rd_data", rows[i].er, d)
            `CHK("res_1000", rows[i].eres, res_1000)
            `CHK("power_mode", rows[i].epm, power_mode)
        end
        // Automatic level shows only while no level is forced
        @(posedge clk) auto_level <= 2'h3;
        rd(1'b0, 7'h2e, d);
        `CHK("mode_auto", 8'hc0, d)
        host.wr(7'h11, 8'h10);
        rd(1'b0, 7'h2e, d);
        `CHK("mode_forced", 8'h40, d)
        // Forced sleep is lifted before frames and bursts
        host.wr(7'h11, 8'h00);
        @(posedge clk) auto_level <= 2'h0;
        // Frames set activity bits; any written value clears them
        foreach (src[k]) begin
            if (k < 2) begin
                frame();
                rd(1'b0, 7'h2e, d);
                `CHK("activity_set", 8'h0f, d)
                host.wr(7'h2e, k == 0 ? 8'hff : 8'h00);
                rd(1'b0, 7'h2e, d);
                `CHK("activity_clear", 8'h00, d)
            end
        end
        // Writes while the clock enable is low leave state alone
        @(posedge clk) ce <= 1'b0;
        host.wr(7'h11, 8'h80);
        @(posedge clk) ce <= 1'b1;
        rd(1'b0, 7'h11, d);
        `CHK("ce_hold", 8'h00, d)
        // Key write brings back every default
        host.wr(7'h11, 8'hb0);
        frame();
        host.wr(7'h3a, 8'h5a);
        repeat (3) @(posedge clk);
        `CHK("soft_count", 1, n_soft)
        rd(1'b0, 7'h11, d);
        `CHK("soft_config", 8'h03, d)
        rd(1'b0, 7'h2e, d);
        `CHK("soft_activity", 8'h00, d)
        // Full burst: seven bytes, clear after the third, then no more
        rd(1'b0, 7'h42, d);
        `CHK("burst0", src[0], d)
        for (int i = 1; i < 7; i++) begin
            if (i < 3)
                `CHK("clear_early", 1'b0, motion_clear)
            rd(1'b1, 7'h00, d);
            `CHK("burst_byte", src[i], d)
            if (i == 2)
                `CHK("clear_pulse", 1'b1, motion_clear)
        end
        `CHK("clear_once", 1, n_clear)
        host.xfer(1'b1, 7'h00, d, ok);
        `CHK("burst_over", 1'b0, ok)
        // Short burst cut off after two bytes clears nothing
        foreach (src[k]) src[k] <= ~src[k];
        rd(1'b0, 7'h42, d);
        `CHK("restart0", src[0], d)
        rd(1'b1, 7'h00, d);
        `CHK("restart1", src[1], d)
        host.stop();
        host.xfer(1'b1, 7'h00, d, ok);
        `CHK("after_end", 1'b0, ok)
        `CHK("clear_short", 1, n_clear)
        // Second hardware reset in mid-run
        host.wr(7'h11, 8'hb0);
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(1'b0, 7'h11, d);
        `CHK("reset_config", 8'h03, d)
        `CHK("reset_mode", 2'h0, power_mode)
        finish_test();
    end
endmodule : tb_sensor_config_status_regs
